// ===== verif/parity_residue_bench.sv
// Self-checking bench for the SCSI parity and residue block.
// Assumes the package and the SCSI peer model are compiled first.
`timescale 1ns/10ps

module parity_residue_bench;
  import parity_residue_pkg::*;
  // ----
  // Signals
  // ----
  logic        ref_clk;
  logic        rst;
  logic        ce;
  wb_req_t     wb_req;
  wb_rsp_t     wb_rsp;
  logic [15:0] rx_data;
  logic        rx_strobe;
  logic [1:0]  peer_par;
  logic [1:0]  peer_oe;
  logic [1:0]  par_o;
  logic [1:0]  par_oe;
  logic [1:0]  par_wire;
  logic        tx_drive;
  logic        tx_load;
  logic [15:0] tx_data;
  logic        initiator;
  logic        xfer_end;
  logic        atn;
  logic        halt;
  logic        pci_phase;
  logic        pci_perr;
  logic        irq;
  logic [9:0]  fifo_count;
  logic [23:0] byte_count;
  core_flags_t core_flags;
  logic [9:0]  fifo_limit;
  logic [31:0] q;
  int          n_mismatch;
  int          checked;

  // 125 MHz clock
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  // Parity pins: whoever enables drives, released lines read zero
  assign par_wire = (par_o & par_oe) | (peer_par & peer_oe & ~par_oe);

  // ----
  // Instances
  // ----
  parity_residue parity_residue_inst (
    .REF_CLK(ref_clk), .RST(rst), .CE(ce), .WB_REQ(wb_req), .WB_RSP(wb_rsp),
    .RX_DATA(rx_data), .RX_STROBE(rx_strobe), .PARITY_LINE_I(par_wire),
    .PARITY_LINE_O(par_o), .PARITY_LINE_OE(par_oe), .TX_DRIVE(tx_drive),
    .TX_LOAD(tx_load), .TX_DATA(tx_data), .INITIATOR(initiator),
    .XFER_END(xfer_end), .ATTENTION_OUTPUT(atn), .HALT_OUT(halt),
    .PCI_DATA_PHASE(pci_phase), .PCI_PERR_SEEN(pci_perr), .IRQ(irq),
    .FIFO_COUNT(fifo_count), .BYTE_COUNT(byte_count), .CORE_FLAGS(core_flags),
    .FIFO_LIMIT(fifo_limit)
  );

  scsi_peer_model scsi_peer_model_inst (
    .clk(ref_clk), .rx_data(rx_data), .rx_strobe(rx_strobe),
    .par_drv(peer_par), .par_oe(peer_oe)
  );

  // ----
  // Shared tasks
  // ----
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Classic cycle: ack is looked at mid-cycle, where it has settled, so the
  // request still stands at the rising edge that samples it; only the
  // watchdog ends a wait that never gets an answer
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    @(posedge ref_clk);
    @(negedge ref_clk);
    while (wb_rsp.ack !== 1'b1) begin
      @(negedge ref_clk);
    end
    q = wb_rsp.dat;
    @(posedge ref_clk);
    wb_req <= '0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset_values();
    logic [7:0] ofs [9];
    ofs = '{OFS_CTRL0, OFS_CTRL1, OFS_CTRL2, OFS_IEN0, OFS_ISTAT0, OFS_CHIP_TEST_FOUR,
            OFS_DMA_STATUS_REG, OFS_DMA_IRQ_ENABLE_REG, 8'h3c};
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk("reset_reg", q, 32'h0);
    end
    chk("limit_reset", 32'(fifo_limit), 32'd88);
  endtask

  // Every check/sense pair; the wire loops back into the live status bits
  task automatic t_tx_parity();
    logic [1:0] exp;
    wr(OFS_CTRL2, 32'h08);
    tx_drive <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tx_data <= 16'h0301 + 16'(i);
      wr(OFS_CTRL0, {28'h0, i[1], 3'h0});
      wr(OFS_CTRL1, {29'h0, i[0], 2'h0});
      tx_load <= 1'b1;
      @(posedge ref_clk);
      tx_load <= 1'b0;
      repeat (4) @(posedge ref_clk);
      exp = {~^tx_data[15:8], ~^tx_data[7:0]} ^ {2{i[0]}};
      chk("tx_parity", 32'(par_o), 32'(exp));
      chk("tx_enable", 32'(par_oe), 32'h3);
      rd(OFS_STAT0);
      chk("live_low", 32'(q[B_LINE]), 32'(exp[0]));
      rd(OFS_STAT2);
      chk("live_high", 32'(q[B_LINE]), 32'(exp[1]));
    end
    tx_drive <= 1'b0;
  endtask

  task automatic t_rx_parity();
    initiator <= 1'b1;
    wr(OFS_CTRL0, 32'h0);
    wr(OFS_CTRL1, 32'h0);
    scsi_peer_model_inst.send_word(16'h0301, 2'b01);
    rd(OFS_ISTAT0);
    chk("perr_off", q, 32'h0);
    chk("halt_off", 32'(halt), 32'h0);
    wr(OFS_CTRL0, 32'h0a);
    scsi_peer_model_inst.send_word(16'h0301, 2'b00);
    rd(OFS_ISTAT0);
    chk("perr_good", q, 32'h0);
    rd(OFS_STAT1);
    chk("latched_low", q & 32'h8, 32'h0);
    rd(OFS_STAT2);
    chk("latched_high", q & 32'h8, 32'h8);
    scsi_peer_model_inst.send_word(16'h8001, 2'b10);
    rd(OFS_ISTAT0);
    chk("perr_high", q, 32'h1);
    chk("atn", 32'(atn), 32'h1);
    chk("halt", 32'(halt), 32'h1);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(OFS_IEN0, 32'h1);
    chk("irq", 32'(irq), 32'h1);
    wr(OFS_ISTAT0, 32'h1);
    chk("irq_clear", 32'(irq), 32'h0);
  endtask

  task automatic t_target_halt();
    initiator <= 1'b0;
    wr(OFS_CTRL1, 32'h20);
    scsi_peer_model_inst.send_word(16'h0055, 2'b01);
    rd(OFS_ISTAT0);
    chk("perr_target", q, 32'h1);
    chk("atn_target", 32'(atn), 32'h0);
    chk("halt_pending", 32'(halt), 32'h0);
    xfer_end <= 1'b1;
    @(posedge ref_clk);
    xfer_end <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("halt_end", 32'(halt), 32'h1);
    wr(OFS_ISTAT0, 32'h1);
    wr(OFS_CTRL1, 32'h0);
    scsi_peer_model_inst.send_word(16'h0055, 2'b01);
    chk("halt_target", 32'(halt), 32'h1);
    wr(OFS_ISTAT0, 32'h1);
  endtask

  task automatic pci_err();
    pci_phase <= 1'b1;
    pci_perr <= 1'b1;
    @(posedge ref_clk);
    pci_phase <= 1'b0;
    pci_perr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic t_pci_master();
    wr(OFS_CHIP_TEST_FOUR, 32'h0);
    pci_err();
    rd(OFS_DMA_STATUS_REG);
    chk("mdpe_off", q, 32'h0);
    wr(OFS_CHIP_TEST_FOUR, 32'h8);
    // Clock enable low freezes the status, so the error is not seen
    ce <= 1'b0;
    pci_err();
    ce <= 1'b1;
    rd(OFS_DMA_STATUS_REG);
    chk("mdpe_frozen", q, 32'h0);
    pci_err();
    rd(OFS_DMA_STATUS_REG);
    chk("mdpe", q, 32'h40);
    chk("irq_mdpe_masked", 32'(irq), 32'h0);
    wr(OFS_DMA_IRQ_ENABLE_REG, 32'h40);
    chk("irq_mdpe", 32'(irq), 32'h1);
    wr(OFS_DMA_STATUS_REG, 32'h40);
    chk("irq_mdpe_clear", 32'(irq), 32'h0);
  endtask

  // Counts chosen so both subtractions wrap through their masks
  task automatic t_residue();
    fifo_count <= 10'h1a5;
    byte_count <= 24'hab0237;
    rd(OFS_BCOUNT);
    chk("byte_count", q, 32'h00ab0237);
    rd(OFS_FIFOCNT);
    chk("fifo_small", q, 32'h25);
    rd(OFS_RESID);
    chk("resid_small", q, 32'h6e);
    wr(OFS_CHIP_TEST_FIVE, 32'h20);
    chk("limit_large", 32'(fifo_limit), 32'd536);
    rd(OFS_CHIP_TEST_FIVE);
    chk("fifo_upper", q, 32'h21);
    rd(OFS_FIFOCNT);
    chk("fifo_large", q, 32'ha5);
    rd(OFS_RESID);
    chk("resid_large", q, 32'h36e);
    wr(OFS_CHIP_TEST_FIVE, 32'h0);
    chk("limit_small", 32'(fifo_limit), 32'd88);
  endtask

  task automatic t_flags();
    core_flags <= '{olat_full: 2'b01, oreg_full: 2'b10, ilat_full: 2'b11,
                    sfifo_cnt: 5'h15, wide_res: 1'b1};
    rd(OFS_STAT0);
    chk("flags_low", q & 32'he0, 32'ha0);
    rd(OFS_STAT2);
    chk("flags_high", q & 32'hf0, 32'hd0);
    rd(OFS_STAT1);
    chk("sync_count", q & 32'hf0, 32'h50);
    rd(OFS_CTRL2);
    chk("wide_res", q, 32'h09);
  endtask

  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wb_req = '0;
    tx_drive = 1'b0;
    tx_load = 1'b0;
    tx_data = 16'h0000;
    initiator = 1'b0;
    xfer_end = 1'b0;
    pci_phase = 1'b0;
    pci_perr = 1'b0;
    fifo_count = 10'h000;
    byte_count = 24'h000000;
    core_flags = '0;
    n_mismatch = 0;
    checked = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset_values();
    t_tx_parity();
    t_rx_parity();
    t_target_halt();
    t_pci_master();
    t_residue();
    t_flags();
    test_done();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    test_done();
  end
endmodule

// ===== verif/scsi_peer_model.sv
// SCSI peer that sends 16-bit words to the block with a receive strobe.
// Assumes send_word is called just after a rising edge of clk.
`timescale 1ns/10ps

module scsi_peer_model (
  input  wire logic   clk,
  output logic [15:0] rx_data,
  output logic        rx_strobe,
  output logic [1:0]  par_drv,
  output logic [1:0]  par_oe
);
  // Idle: lines released, pull-ups read as logical zero
  initial begin
    rx_data = 16'h0000;
    rx_strobe = 1'b0;
    par_drv = 2'b00;
    par_oe = 2'b00;
  end

  // One word; bad flips the parity of the lanes set in it
  task automatic send_word(input logic [15:0] d, input logic [1:0] bad);
    rx_data <= d;
    par_drv <= {~^d[15:8], ~^d[7:0]} ^ bad;
    par_oe <= 2'b11;
    repeat (2) @(posedge clk);
    // Strobe kept high and low 3 cycles each, so the synchroniser sees it
    rx_strobe <= 1'b1;
    repeat (3) @(posedge clk);
    rx_strobe <= 1'b0;
    repeat (3) @(posedge clk);
    rx_data <= 16'h0000;
    par_oe <= 2'b00;
    repeat (2) @(posedge clk);
  endtask
endmodule

// ===== verilog/parity_residue.sv
// SCSI parity generation and checking, PCI master parity status and
// data path residue reporting, behind a classic Wishbone slave.
// Assumes the transfer engine and PCI master run on REF_CLK; SCSI pins are
// asynchronous and pass two flip-flops first.
//
// Behaviour
// - Check enabled: received bytes checked for odd parity
// - Always generate parity, even or odd by select
// - Checking disabled: no parity errors reported
// - Initiator with attention enable: raise ATN on error
// - Halt disable clear: halt on any parity error
// - Target with halt disable: halt after transfer ends
// - Parity error status set on every detected error
// - Parity interrupt only when its enable is set
// - Live parity line states readable, active high
// - Odd parity of latched input data per lane
// - Master parity enable gates master phase checking
// - Target reported data parity error sets master status
// - Master error interrupt masked by its enable
// - DMA FIFO four lanes by 134 entries
// - FIFO limit 88 bytes, or 536 when selected
// - Small mode: 7-bit counter, residue masked 7Fh
// - Large mode: 10-bit counter, residue masked 3FFh
// - Output latch full flag per byte lane
// - Output register full flag per byte lane
// - Input latch full flag per byte lane
// - Sync receive FIFO byte count, five bits
// - Wide residue byte held status bit

`timescale 1ns/10ps

module parity_residue
  import parity_residue_pkg::FIFO_LANES_DEF;
  import parity_residue_pkg::FIFO_DEPTH_DEF;
#(
  parameter int FIFO_LANES = FIFO_LANES_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic                            REF_CLK,
  input  wire logic                            RST,
  input  wire logic                            CE,
  input  wire parity_residue_pkg::wb_req_t     WB_REQ,
  output parity_residue_pkg::wb_rsp_t          WB_RSP,
  input  wire logic [15:0]                     RX_DATA,
  input  wire logic                            RX_STROBE,
  input  wire logic [1:0]                      PARITY_LINE_I,
  output logic [1:0]                           PARITY_LINE_O,
  output logic [1:0]                           PARITY_LINE_OE,
  input  wire logic                            TX_DRIVE,
  input  wire logic                            TX_LOAD,
  input  wire logic [15:0]                     TX_DATA,
  input  wire logic                            INITIATOR,
  input  wire logic                            XFER_END,
  output logic                                 ATTENTION_OUTPUT,
  output logic                                 HALT_OUT,
  input  wire logic                            PCI_DATA_PHASE,
  input  wire logic                            PCI_PERR_SEEN,
  output logic                                 IRQ,
  input  wire logic [9:0]                      FIFO_COUNT,
  input  wire logic [23:0]                     BYTE_COUNT,
  input  wire parity_residue_pkg::core_flags_t CORE_FLAGS,
  output logic [9:0]                           FIFO_LIMIT
);
  import parity_residue_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int FIFO_BYTES = FIFO_LANES * FIFO_DEPTH;

  // The offset counter is ten bits wide, so the FIFO may not exceed it
  if (FIFO_LANES < 1 || FIFO_BYTES < FIFO_SMALL_BYTES || FIFO_BYTES >= (1 << CNT_W)) begin : g_bad
    $error("FIFO size not served by a ten-bit offset counter");
  end

  // ----------------------------------------------------------------
  // State and lane logic
  // ----------------------------------------------------------------
  st_t        q;
  st_t        n;
  logic [1:0] rx_mis;
  logic [1:0] tx_par;
  logic [1:0] lat_par;
  logic [1:0] lane_on;
  logic       rx_ev;
  logic       perr_ev;
  logic       mdp_ev;
  logic       req;
  logic       wr;
  logic       clr_perr;
  logic       clr_mdpe;
  logic [6:0] res_small;
  logic [9:0] res_large;
  logic [9:0] residue;
  logic [7:0] tx_lo;

  assign tx_lo = TX_DATA[7:0];

  // High lane only counts while the bus is 16 bits wide
  assign lane_on = {q.wide, 1'b1};

  // Per-lane parity: check, generate and latched value
  for (genvar l = 0; l < 2; l++) begin : g_lane
    assign rx_mis[l]  = lane_on[l] & ~(^{q.rx_s2[8*l +: 8], q.rp_s2[l]});
    assign tx_par[l]  = q.even ? (^TX_DATA[8*l +: 8]) : ~(^TX_DATA[8*l +: 8]);
    assign lat_par[l] = ~(^q.ilat[8*l +: 8]);
  end

  // Strobe edge from the synchronised copy, never the first stage
  assign rx_ev   = q.stb_s2 & ~q.stb_s3;
  assign perr_ev = rx_ev & q.chk_en & (|rx_mis);
  assign mdp_ev  = q.mpe & PCI_DATA_PHASE & PCI_PERR_SEEN;

  // Bus decode: a write lands at the edge where ack is sampled
  assign req      = WB_REQ.cyc & WB_REQ.stb;
  assign wr       = req & q.ack & WB_REQ.we & WB_REQ.sel[0];
  assign clr_perr = wr & (WB_REQ.adr == OFS_ISTAT0) & WB_REQ.dat[B_PERR];
  assign clr_mdpe = wr & (WB_REQ.adr == OFS_DMA_STATUS_REG) & WB_REQ.dat[B_MDPE];

  // Residue, with the mask that the FIFO size selects
  assign res_small = FIFO_COUNT[6:0] - BYTE_COUNT[6:0];
  assign res_large = FIFO_COUNT - BYTE_COUNT[9:0];
  assign residue   = q.fsize ? res_large : {3'h0, res_small};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] rdat;
    rdat = RD_ZERO;
    n    = q;

    // Pin synchronisers
    n.rx_s1  = RX_DATA;
    n.rx_s2  = q.rx_s1;
    n.rp_s1  = PARITY_LINE_I;
    n.rp_s2  = q.rp_s1;
    n.stb_s1 = RX_STROBE;
    n.stb_s2 = q.stb_s1;
    n.stb_s3 = q.stb_s2;

    // Input latch and outgoing parity
    if (rx_ev) begin
      n.ilat = q.rx_s2;
    end
    if (TX_LOAD) begin
      n.txp = tx_par;
    end

    // Software clears come first so that a same-cycle event wins
    if (clr_perr) begin
      n.perr = 1'b0;
      n.atn  = 1'b0;
      n.halt = 1'b0;
      n.pend = 1'b0;
    end
    if (clr_mdpe) begin
      n.mdpe = 1'b0;
    end

    // SCSI parity error reaction
    if (perr_ev) begin
      n.perr = 1'b1;
      if (q.atn_en && INITIATOR) begin
        n.atn = 1'b1;
      end
      if (q.halt_on_error_disable && !INITIATOR) begin
        n.pend = 1'b1;
      end else begin
        n.halt = 1'b1;
      end
    end

    // Deferred halt waits for the transfer to close
    if (n.pend && XFER_END) begin
      n.pend = 1'b0;
      n.halt = 1'b1;
    end

    if (mdp_ev) begin
      n.mdpe = 1'b1;
    end

    // Control writes
    if (wr) begin
      unique case (WB_REQ.adr)
        OFS_CTRL0: begin
          n.chk_en = WB_REQ.dat[B_CHK];
          n.atn_en = WB_REQ.dat[B_ATN];
        end
        OFS_CTRL1: begin
          n.even = WB_REQ.dat[B_EVEN];
          n.halt_on_error_disable  = WB_REQ.dat[B_DHP];
        end
        OFS_CTRL2:  n.wide  = WB_REQ.dat[B_WIDE];
        OFS_IEN0:   n.pie   = WB_REQ.dat[B_PIE];
        OFS_CHIP_TEST_FOUR: n.mpe   = WB_REQ.dat[B_MPE];
        OFS_CHIP_TEST_FIVE: n.fsize = WB_REQ.dat[B_FSIZE];
        OFS_DMA_IRQ_ENABLE_REG:   n.mie   = WB_REQ.dat[B_MDPE];
        default: ;
      endcase
    end

    // Read mux; unmapped offsets read zero
    unique case (WB_REQ.adr)
      OFS_CTRL0: begin
        rdat[B_CHK] = q.chk_en;
        rdat[B_ATN] = q.atn_en;
      end
      OFS_CTRL1: begin
        rdat[B_EVEN] = q.even;
        rdat[B_DHP]  = q.halt_on_error_disable;
      end
      OFS_CTRL2: begin
        rdat[B_WRCV] = CORE_FLAGS.wide_res;
        rdat[B_WIDE] = q.wide;
      end
      OFS_IEN0:   rdat[B_PIE]  = q.pie;
      OFS_ISTAT0: rdat[B_PERR] = q.perr;
      OFS_STAT0: begin
        rdat[B_LINE] = q.rp_s2[0];
        rdat[B_OLAT] = CORE_FLAGS.olat_full[0];
        rdat[B_OREG] = CORE_FLAGS.oreg_full[0];
        rdat[B_ILAT] = CORE_FLAGS.ilat_full[0];
      end
      OFS_STAT1: begin
        rdat[B_LPAR]             = lat_par[0];
        rdat[B_SCNT_LO +: 4]     = CORE_FLAGS.sfifo_cnt[3:0];
      end
      OFS_STAT2: begin
        rdat[B_LINE]     = q.rp_s2[1];
        rdat[B_LPAR]     = lat_par[1];
        rdat[B_SCNT_HI]  = CORE_FLAGS.sfifo_cnt[4];
        rdat[B_OLAT]     = CORE_FLAGS.olat_full[1];
        rdat[B_OREG]     = CORE_FLAGS.oreg_full[1];
        rdat[B_ILAT]     = CORE_FLAGS.ilat_full[1];
      end
      OFS_CHIP_TEST_FOUR: rdat[B_MPE] = q.mpe;
      OFS_CHIP_TEST_FIVE: begin
        rdat[B_FSIZE] = q.fsize;
        rdat[1:0]     = q.fsize ? FIFO_COUNT[9:8] : 2'h0;
      end
      OFS_DMA_STATUS_REG: rdat[B_MDPE] = q.mdpe;
      OFS_DMA_IRQ_ENABLE_REG:  rdat[B_MDPE] = q.mie;
      // Small mode shows only seven counter bits
      OFS_FIFOCNT: rdat[7:0] = q.fsize ? FIFO_COUNT[7:0] : {1'b0, FIFO_COUNT[6:0]};
      OFS_BCOUNT:  rdat[23:0] = BYTE_COUNT;
      OFS_RESID:   rdat[9:0]  = residue;
      default: ;
    endcase

    // One wait state, then ack for exactly one cycle
    n.ack = req & ~q.ack;
    if (req && !q.ack) begin
      n.dat = rdat;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Clock enable freezes everything, the bus handshake included
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q <= ST_RST;
    end else if (CE) begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign WB_RSP.ack       = q.ack;
  assign WB_RSP.dat       = q.dat;
  assign PARITY_LINE_O    = q.txp;
  // High lane parity is driven only on a wide bus
  assign PARITY_LINE_OE   = {TX_DRIVE & q.wide, TX_DRIVE};
  assign ATTENTION_OUTPUT = q.atn;
  assign HALT_OUT         = q.halt;
  assign IRQ              = (q.perr & q.pie) | (q.mdpe & q.mie);
  assign FIFO_LIMIT       = q.fsize ? 10'(FIFO_BYTES) : 10'(FIFO_SMALL_BYTES);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  sequence s_defer;
    CE && perr_ev && q.halt_on_error_disable && !INITIATOR && !q.halt && !XFER_END;
  endsequence

  sequence s_req;
    CE && req && !q.ack;
  endsequence

  a_odd_check: assert property (
    CE && rx_ev && q.chk_en && !(^{q.rx_s2[7:0], q.rp_s2[0]}) |=> q.perr)
    else $error("odd parity mismatch not flagged");

  a_tx_parity: assert property (
    CE && TX_LOAD |=> PARITY_LINE_O[0] == ($past(q.even) ? ^$past(tx_lo) : ~^$past(tx_lo)))
    else $error("wrong generated parity sense");

  a_check_off: assert property (
    CE && !q.chk_en && !q.perr |=> !q.perr)
    else $error("parity error with checking disabled");

  a_atn_init: assert property (
    CE && perr_ev && q.atn_en && INITIATOR |=> ATTENTION_OUTPUT)
    else $error("attention not raised on error");

  a_halt_now: assert property (
    CE && perr_ev && !(q.halt_on_error_disable && !INITIATOR) |=> HALT_OUT)
    else $error("no halt on parity error");

  a_halt_defer: assert property (
    s_defer |=> !HALT_OUT && q.pend)
    else $error("deferred halt taken early");

  a_halt_end: assert property (
    CE && q.pend && XFER_END && !clr_perr |=> HALT_OUT && !q.pend)
    else $error("no halt at transfer end");

  a_perr_sticky: assert property (
    CE && perr_ev |=> q.perr [*1] ##1 (q.perr || $past(clr_perr)))
    else $error("parity status not set");

  a_irq_scsi: assert property (
    !q.pie && !(q.mdpe && q.mie) |-> !IRQ)
    else $error("interrupt with parity enable clear");

  a_mdp_off: assert property (
    CE && !q.mpe && !q.mdpe |=> !q.mdpe)
    else $error("master parity set while disabled");

  a_mdp_set: assert property (
    CE && mdp_ev |=> q.mdpe)
    else $error("master parity status not set");

  a_irq_master: assert property (
    !q.mie && !(q.perr && q.pie) |-> !IRQ)
    else $error("interrupt with master enable clear");

  a_fifo_limit: assert property (
    FIFO_LIMIT == (q.fsize ? 10'h218 : 10'h058))
    else $error("FIFO limit wrong for size select");

  a_bus_ack: assert property (
    s_req |=> WB_RSP.ack ##1 (!WB_RSP.ack || !$past(CE)))
    else $error("ack not one cycle after request");

endmodule

// ===== verilog/parity_residue_pkg.sv
// Constants, register map and carrier types for the SCSI parity and residue block.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.

package parity_residue_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL0   = 8'h00; // scsi_control_zero
  localparam logic [7:0] OFS_CTRL1   = 8'h04; // scsi_control_one
  localparam logic [7:0] OFS_CTRL2   = 8'h08; // scsi_control_two
  localparam logic [7:0] OFS_IEN0    = 8'h0c; // scsi_irq_enable_zero
  localparam logic [7:0] OFS_ISTAT0  = 8'h10; // scsi_irq_status_zero
  localparam logic [7:0] OFS_STAT0   = 8'h14; // scsi_status_zero
  localparam logic [7:0] OFS_STAT1   = 8'h18; // scsi_status_one
  localparam logic [7:0] OFS_STAT2   = 8'h1c; // scsi_status_two
  localparam logic [7:0] OFS_CHIP_TEST_FOUR  = 8'h20; // chip_test_four
  localparam logic [7:0] OFS_CHIP_TEST_FIVE  = 8'h24; // chip_test_five
  localparam logic [7:0] OFS_DMA_STATUS_REG   = 8'h28; // dma_status_reg
  localparam logic [7:0] OFS_DMA_IRQ_ENABLE_REG    = 8'h2c; // dma_irq_enable_reg
  localparam logic [7:0] OFS_FIFOCNT = 8'h30; // fifo_byte_counter
  localparam logic [7:0] OFS_BCOUNT  = 8'h34; // byte_count_reg
  localparam logic [7:0] OFS_RESID   = 8'h38; // residual byte count

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_ATN     = 1; // control zero: attention on error
  localparam int B_CHK     = 3; // control zero: parity_check_enable
  localparam int B_EVEN    = 2; // control one: even_parity_select
  localparam int B_DHP     = 5; // control one: halt_on_error_disable
  localparam int B_WRCV    = 0; // control two: wide residue held
  localparam int B_WIDE    = 3; // control two: 16-bit lanes active
  localparam int B_PIE     = 0; // parity error interrupt enable
  localparam int B_PERR    = 0; // parity error status
  localparam int B_LINE    = 0; // live parity line
  localparam int B_LPAR    = 3; // latched input parity
  localparam int B_SCNT_HI = 4; // status two: sync count bit 4
  localparam int B_SCNT_LO = 4; // status one: sync count bits 7-4
  localparam int B_OLAT    = 5; // output latch full
  localparam int B_OREG    = 6; // output register full
  localparam int B_ILAT    = 7; // input latch full
  localparam int B_MPE     = 3; // chip test four: master parity enable
  localparam int B_FSIZE   = 5; // chip test five: large FIFO select
  localparam int B_MDPE    = 6; // master data parity error

  // ----------------------------------------------------------------
  // Sizes, masks and reset values
  // ----------------------------------------------------------------
  localparam int          FIFO_LANES_DEF   = 4;
  localparam int          FIFO_DEPTH_DEF   = 134;
  localparam int          FIFO_SMALL_BYTES = 88;
  localparam int          CNT_W            = 10;
  localparam logic [31:0] RD_ZERO          = 32'h0000_0000;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Data path occupancy reported by the transfer engine
  typedef struct packed {
    logic [1:0] olat_full;
    logic [1:0] oreg_full;
    logic [1:0] ilat_full;
    logic [4:0] sfifo_cnt;
    logic       wide_res;
  } core_flags_t;

  // Whole state of the block
  typedef struct packed {
    logic [15:0] rx_s1;
    logic [15:0] rx_s2;
    logic [1:0]  rp_s1;
    logic [1:0]  rp_s2;
    logic        stb_s1;
    logic        stb_s2;
    logic        stb_s3;
    logic [15:0] ilat;
    logic [1:0]  txp;
    logic        chk_en;
    logic        atn_en;
    logic        even;
    logic        halt_on_error_disable;
    logic        wide;
    logic        pie;
    logic        mpe;
    logic        fsize;
    logic        mie;
    logic        perr;
    logic        mdpe;
    logic        atn;
    logic        halt;
    logic        pend;
    logic        ack;
    logic [31:0] dat;
  } st_t;

  localparam st_t ST_RST = '0;

endpackage
